// ---- hw/psm_ctrl.v ----
// power save mode controller: sleep, idle and deep sleep sequencing
`timescale 1ns/1ns
`include "psm_defs.vh"
// Overview of operation
// - sleep stops clocks and code execution
// - idle halts cpu, peripherals keep running
// - deep sleep stops all but calendar, watchdog
// - sleep shuts down system clock oscillator
// - sleep freezes pin directions and outputs
// - fail-safe monitor off during sleep
// - sleep keeps rc clock for its users
// - sleep entry clears enabled watchdog
// - sleep disables system-clocked peripherals
// - sleep wakes on interrupt, reset, timeout
// - sleep wake resumes same clock source
// - idle entry clears the watchdog
// - idle keeps system clock and peripherals
// - idle keeps rc clock for watchdog, monitor
// - idle wakes on interrupt, reset, timeout
// - idle wake restarts cpu immediately
// - coincident interrupt deferred, then wakes sleep or idle
// - clock switch only when not locked
// - arm bit is bit fifteen of control
// - arm bit self-clears on the fourth instruction cycle
module psm_ctrl #(
    parameter OSC_SEL_W = 3
) (
    input wire ref_clk,
    input wire rst_b,
    input wire clk_en,
    input wire instr_cycle,
    input wire pwrsav_req,
    input wire pwrsav_op,
    input wire dsc_wr,
    input wire [15:0] dsc_wdata,
    output wire [15:0] dsc_rdata,
    input wire irq_pending,
    input wire wdt_timeout,
    input wire ext_reset_pin,
    input wire wdt_en,
    input wire wdt_on_low_power_rc_clock,
    input wire rtc_en,
    input wire rtc_on_low_power_rc_clock,
    input wire fail_safe_clock_monitor_en,
    input wire clk_locked,
    input wire osc_switch_req,
    input wire [OSC_SEL_W-1:0] new_oscillator_select,
    output reg [OSC_SEL_W-1:0] active_osc_r,
    output reg [3:0] mode_r,
    output wire cpu_clk_en,
    output wire sys_clk_en,
    output wire sys_osc_en,
    output wire periph_clk_en,
    output wire fail_safe_clock_monitor_active,
    output wire low_power_rc_clock_en,
    output wire io_freeze,
    output wire mem_power_en,
    output wire keep_calendar_wdt,
    output reg wdt_clear_r,
    output reg wake_r
);
    wire ext_reset_s;
    wire deep_sleep_arm_bit;
    wire arm_clr;
    wire enter_sleep;
    wire enter_idle;
    wire enter_deep;
    wire wake_src;
    reg [3:0] mode_nxt;
    reg irq_defer_r;

    // pin reset passes the three-stage filter before use
    psm_sync3 u_rst_sync (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .async_in(ext_reset_pin),
        .sync_out(ext_reset_s)
    );

    psm_arm_timer u_arm (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .instr_cycle(instr_cycle),
        .arm_set(dsc_wr && dsc_wdata[`PSM_DSC_ARM_BIT]),
        .arm_clr(arm_clr),
        .arm_r(deep_sleep_arm_bit)
    );

    // control register readback; other bits read zero
    assign dsc_rdata = `PSM_DSC_RESET | ({15'h0000, deep_sleep_arm_bit} << `PSM_DSC_ARM_BIT);

    // deep sleep only when armed first
    assign enter_sleep = pwrsav_req && (mode_r == `PSM_ST_RUN) && (pwrsav_op == `PSM_OP_SLEEP)
                         && !deep_sleep_arm_bit;
    assign enter_deep = pwrsav_req && (mode_r == `PSM_ST_RUN) && (pwrsav_op == `PSM_OP_SLEEP)
                        && deep_sleep_arm_bit;
    assign enter_idle = pwrsav_req && (mode_r == `PSM_ST_RUN) && (pwrsav_op == `PSM_OP_IDLE);
    // arm consumed on deep entry, or dropped by software writing zero
    assign arm_clr = enter_deep || (dsc_wr && !dsc_wdata[`PSM_DSC_ARM_BIT]);

    assign wake_src = irq_pending || irq_defer_r || wdt_timeout || ext_reset_s;

    // mode sequencing; deep sleep leaves only through device reset
    always @* begin
        mode_nxt = mode_r;
        case (mode_r)
            `PSM_ST_RUN: begin
                if (enter_deep) begin
                    mode_nxt = `PSM_ST_DEEP;
                end else if (enter_sleep) begin
                    mode_nxt = `PSM_ST_SLEEP;
                end else if (enter_idle) begin
                    mode_nxt = `PSM_ST_IDLE;
                end
            end
            `PSM_ST_SLEEP, `PSM_ST_IDLE: begin
                if (wake_src) begin
                    mode_nxt = `PSM_ST_RUN;
                end
            end
            `PSM_ST_DEEP: begin
                mode_nxt = `PSM_ST_DEEP;
            end
            default: begin
                mode_nxt = `PSM_ST_RUN;
            end
        endcase
    end

    // mode register, wake pulse and watchdog clear pulse
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            mode_r <= `PSM_ST_RUN;
            wake_r <= 1'b0;
            wdt_clear_r <= 1'b0;
            irq_defer_r <= 1'b0;
        end else if (clk_en) begin
            mode_r <= mode_nxt;
            // wake pulse restarts cpu next cycle
            wake_r <= (mode_r != `PSM_ST_RUN) && (mode_r != `PSM_ST_DEEP) && (mode_nxt == `PSM_ST_RUN);
            wdt_clear_r <= (enter_sleep && wdt_en) || enter_idle;
            // coincident interrupt held until entry done
            // a deep-sleep entry drops any pending interrupt instead
            irq_defer_r <= (enter_sleep || enter_idle) && irq_pending;
        end
    end

    // switch only while unlocked and running
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            active_osc_r <= {OSC_SEL_W{1'b0}};
        end else if (clk_en) begin
            if (osc_switch_req && !clk_locked && (mode_r == `PSM_ST_RUN)) begin
                active_osc_r <= new_oscillator_select;
            end
        end
    end

    assign cpu_clk_en = (mode_r == `PSM_ST_RUN);
    // system oscillator off in sleep and deep sleep
    assign sys_osc_en = (mode_r == `PSM_ST_RUN) || (mode_r == `PSM_ST_IDLE);
    assign sys_clk_en = sys_osc_en;
    assign periph_clk_en = sys_osc_en;
    // monitor idle while its clock is gone
    assign fail_safe_clock_monitor_active = fail_safe_clock_monitor_en && sys_osc_en;
    // rc clock for users in sleep
    // rc clock for watchdog or monitor
    assign low_power_rc_clock_en =
        ((mode_r == `PSM_ST_SLEEP) && ((wdt_en && wdt_on_low_power_rc_clock) || (rtc_en && rtc_on_low_power_rc_clock)))
        || ((mode_r != `PSM_ST_SLEEP) && (mode_r != `PSM_ST_DEEP) && (wdt_en || fail_safe_clock_monitor_en))
        || ((mode_r == `PSM_ST_DEEP) && rtc_en && rtc_on_low_power_rc_clock);
    // deep sleep freezes pins, cuts memory
    assign io_freeze = (mode_r == `PSM_ST_SLEEP) || (mode_r == `PSM_ST_DEEP);
    assign mem_power_en = (mode_r != `PSM_ST_DEEP);
    assign keep_calendar_wdt = (mode_r == `PSM_ST_DEEP);
endmodule // psm_ctrl

// ---- hw/psm_defs.vh ----
// constants for the power save mode controller
`ifndef PSM_DEFS_VH
`define PSM_DEFS_VH
// power-save instruction operand encoding
`define PSM_OP_SLEEP 1'h0
`define PSM_OP_IDLE 1'h1
// deep-sleep control register layout
`define PSM_DSC_WIDTH 16
`define PSM_DSC_ARM_BIT 15
`define PSM_DSC_RESET 16'h0000
// instruction cycles allowed between arming and the instruction
`define PSM_ARM_WINDOW 2'h3
// mode encoding, one-hot
`define PSM_ST_RUN 4'h1
`define PSM_ST_SLEEP 4'h2
`define PSM_ST_IDLE 4'h4
`define PSM_ST_DEEP 4'h8
`endif

// ---- hw/psm_sync3.v ----
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module psm_sync3 (
    input wire ref_clk,
    input wire rst_b,
    input wire clk_en,
    input wire async_in,
    output reg sync_out
);
    reg s1_r;
    reg s2_r;
    reg s3_r;

    // first stage feeds only the second; output moves when stages two and three agree
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            sync_out <= 1'b0;
        end else if (clk_en) begin
            s1_r <= async_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                sync_out <= s3_r;
            end
        end
    end
endmodule // psm_sync3

// ---- hw/psm_arm_timer.v ----
// deep-sleep arm bit with its self-clearing window
`timescale 1ns/1ns
`include "psm_defs.vh"
module psm_arm_timer (
    input wire ref_clk,
    input wire rst_b,
    input wire clk_en,
    input wire instr_cycle,
    input wire arm_set,
    input wire arm_clr,
    output reg arm_r
);
    reg [1:0] win_cnt_r;

    // counts instruction cycles since arming; set wins over any clear
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            arm_r <= 1'b0;
            win_cnt_r <= 2'h0;
        end else if (clk_en) begin
            if (arm_set) begin
                arm_r <= 1'b1;
                win_cnt_r <= 2'h0;
            end else if (arm_clr) begin
                arm_r <= 1'b0;
                win_cnt_r <= 2'h0;
            end else if (arm_r && instr_cycle) begin
                if (win_cnt_r == `PSM_ARM_WINDOW) begin
                    arm_r <= 1'b0;
                    win_cnt_r <= 2'h0;
                end else begin
                    win_cnt_r <= win_cnt_r + 2'h1;
                end
            end
        end
    end
endmodule // psm_arm_timer

// ---- verif/psm_core_model.sv ----
// processor core stand-in issuing power-save instructions
`timescale 1ns/1ns
module psm_core_model (
    input wire ref_clk,
    output reg pwrsav_req = 1'h0,
    output reg pwrsav_op = 1'h1,
    output reg dsc_wr = 1'h0,
    output reg [15:0] dsc_wdata = 16'h7FFF,
    output reg instr_cycle = 1'h0
);
task issue(input op);
begin
    @(negedge ref_clk);
    pwrsav_req = 1'h1;
    pwrsav_op = op;
    @(negedge ref_clk);
    pwrsav_req = 1'h0;
    pwrsav_op = ~op; // released operand never holds its value
end
endtask
task arm;
begin
    @(negedge ref_clk);
    dsc_wr = 1'h1;
    dsc_wdata = 16'h8000;
    @(negedge ref_clk);
    dsc_wr = 1'h0;
    dsc_wdata = 16'h7FFF;
end
endtask
// one elapsed instruction cycle
task tick;
begin
    @(negedge ref_clk);
    instr_cycle = 1'h1;
    @(negedge ref_clk);
    instr_cycle = 1'h0;
end
endtask
endmodule // psm_core_model

// ---- verif/psm_ctrl_sva.sv ----
// assertions for the power save mode controller
`timescale 1ns/1ns
module psm_ctrl_sva #(parameter OSC_SEL_W = 3) (
    input wire ref_clk, rst_b, clk_en, pwrsav_req, pwrsav_op, irq_pending, wdt_timeout,
    input wire wdt_en, wdt_on_low_power_rc_clock, fail_safe_clock_monitor_en, clk_locked,
    input wire [15:0] dsc_rdata,
    input wire [OSC_SEL_W-1:0] active_osc_r,
    input wire [3:0] mode_r,
    input wire cpu_clk_en, sys_clk_en, sys_osc_en, periph_clk_en, fail_safe_clock_monitor_active,
    input wire low_power_rc_clock_en, io_freeze, mem_power_en, wdt_clear_r, wake_r
);
default clocking @(posedge ref_clk); endclocking
default disable iff (!rst_b);
// instruction taken in run, with arm state
sequence s_take(op, armed);
    clk_en && pwrsav_req && pwrsav_op == op && mode_r == 4'h1 && dsc_rdata[15] == armed;
endsequence
// wake source seen while sleeping or idle
sequence s_wake;
    clk_en && (mode_r == 4'h2 || mode_r == 4'h4) && (irq_pending || wdt_timeout);
endsequence
a_sleep_entry:
    assert property (s_take(1'h0, 1'h0) |=> mode_r == 4'h2) else $error("sleep not entered");
a_deep_entry:
    assert property (s_take(1'h0, 1'h1) |=> mode_r == 4'h8 && !mem_power_en) else $error("deep not entered");
a_idle_entry:
    assert property (s_take(1'h1, 1'h0) |=> mode_r == 4'h4 && wdt_clear_r) else $error("idle not entered");
a_sleep_wdt_clear:
    assert property (s_take(1'h0, 1'h0) ##0 wdt_en |=> wdt_clear_r) else $error("watchdog not cleared");
a_sleep_gates:
    assert property (mode_r == 4'h2 |-> !sys_osc_en && !cpu_clk_en && !periph_clk_en && io_freeze && !fail_safe_clock_monitor_active)
        else $error("sleep gating wrong");
a_idle_gates:
    assert property (mode_r == 4'h4 |-> sys_clk_en && periph_clk_en && !cpu_clk_en
        && (low_power_rc_clock_en || !(wdt_en || fail_safe_clock_monitor_en))) else $error("idle gating wrong");
a_sleep_rc:
    assert property (mode_r == 4'h2 && wdt_en && wdt_on_low_power_rc_clock |-> low_power_rc_clock_en) else $error("rc clock off");
a_wake_seq:
    assert property (s_wake |=> mode_r == 4'h1 && wake_r) else $error("wake sequence wrong");
a_deep_hold:
    assert property (mode_r == 4'h8 |=> mode_r == 4'h8) else $error("deep sleep left");
a_osc_lock:
    assert property ($changed(active_osc_r) |-> !$past(clk_locked)) else $error("locked source changed");
a_osc_keep:
    assert property (mode_r == 4'h2 |=> $stable(active_osc_r)) else $error("source changed in sleep");
endmodule // psm_ctrl_sva
bind psm_ctrl psm_ctrl_sva #(.OSC_SEL_W(OSC_SEL_W)) u_sva (.*);

// ---- verif/tb.sv ----
// self-checking bench for the power save mode controller
`timescale 1ns/1ns
`include "psm_defs.vh"
module tb;
reg ref_clk = 1'h0, rst_b = 1'h0, irq_pending = 1'h0, wdt_timeout = 1'h0, wdt_en = 1'h0;
reg fail_safe_clock_monitor_en = 1'h0, clk_locked = 1'h0, osc_switch_req = 1'h0;
reg [2:0] new_oscillator_select = 3'h0;
wire pwrsav_req, pwrsav_op, dsc_wr, instr_cycle;
wire [15:0] dsc_wdata, dsc_rdata;
wire [2:0] active_osc_r;
wire [3:0] mode_r;
wire cpu_clk_en, sys_clk_en, sys_osc_en, periph_clk_en, fail_safe_clock_monitor_active, low_power_rc_clock_en;
wire io_freeze, mem_power_en, keep_calendar_wdt, wdt_clear_r, wake_r;
integer bad_count = 0, tests_run = 0;
// 50 ns period
always #25 ref_clk = ~ref_clk;
psm_core_model core (.*);
// no calendar and no pin reset, watchdog runs on the rc clock
psm_ctrl DUT (.clk_en(1'h1), .ext_reset_pin(1'h0), .rtc_en(1'h0), .rtc_on_low_power_rc_clock(1'h0), .wdt_on_low_power_rc_clock(1'h1), .*);
task chk(input string what, input [15:0] seen, input [15:0] exp);
begin
    tests_run = tests_run + 1;
    if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("wrong value %s exp %h seen %h", what, exp, seen);
    end
end
endtask
task cyc(input integer n);
    repeat (n) @(negedge ref_clk);
endtask
// held long enough to flush the pin filter
task rst;
begin
    rst_b = 1'h0;
    cyc(20);
    rst_b = 1'h1;
    chk("mode", mode_r, `PSM_ST_RUN);
    chk("arm", dsc_rdata, 16'h0);
end
endtask
// request a source switch, give it two cycles
task sw(input lk, input [2:0] sel, input [2:0] exp);
begin
    clk_locked = lk;
    new_oscillator_select = sel;
    osc_switch_req = 1'h1;
    cyc(1);
    osc_switch_req = 1'h0;
    cyc(2);
    chk("osc", active_osc_r, exp);
end
endtask
// enabled interrupt wakes; pulse rises on the same edge as run
task wake;
begin
    irq_pending = 1'h1;
    cyc(1);
    irq_pending = 1'h0;
    chk("mode", mode_r, `PSM_ST_RUN);
    chk("wake", wake_r, 1'h1);
    cyc(1);
    chk("wake_end", wake_r, 1'h0);
end
endtask
task t_sleep;
begin
    wdt_en = 1'h1;
    core.issue(`PSM_OP_SLEEP);
    chk("mode", mode_r, `PSM_ST_SLEEP);
    chk("wclr", wdt_clear_r, 1'h1);
    chk("osc_en", sys_osc_en, 1'h0);
    chk("frz", io_freeze, 1'h1);
    chk("fail_safe_clock_monitor", fail_safe_clock_monitor_active, 1'h0);
    chk("rc", low_power_rc_clock_en, 1'h1);
    chk("per", periph_clk_en, 1'h0);
    // unlocked switch request while asleep must not move the source
    clk_locked = 1'h0;
    new_oscillator_select = 3'h3;
    osc_switch_req = 1'h1;
    cyc(1);
    osc_switch_req = 1'h0;
    chk("osc", active_osc_r, 3'h5);
    wake;
    chk("osc", active_osc_r, 3'h5);
end
endtask
task t_idle;
begin
    wdt_en = 1'h0;
    fail_safe_clock_monitor_en = 1'h1;
    core.issue(`PSM_OP_IDLE);
    chk("mode", mode_r, `PSM_ST_IDLE);
    chk("wclr", wdt_clear_r, 1'h1);
    chk("sys", {sys_clk_en, periph_clk_en, cpu_clk_en}, 3'h6);
    chk("rc", low_power_rc_clock_en, 1'h1);
    wdt_timeout = 1'h1;
    cyc(1);
    wdt_timeout = 1'h0;
    chk("mode", mode_r, `PSM_ST_RUN);
    chk("wake", wake_r, 1'h1);
    cyc(1);
    chk("wake_end", wake_r, 1'h0);
end
endtask
// interrupt already pending when the instruction runs
task t_coinc;
begin
    irq_pending = 1'h1;
    core.issue(`PSM_OP_SLEEP);
    // drop the line so only the held-off interrupt can wake
    irq_pending = 1'h0;
    chk("mode", mode_r, `PSM_ST_SLEEP);
    cyc(1);
    chk("mode", mode_r, `PSM_ST_RUN);
    chk("wake", wake_r, 1'h1);
end
endtask
// arm lapses after the fourth instruction cycle
task t_window;
begin
    core.arm;
    chk("arm", dsc_rdata, 16'h8000);
    repeat (3) core.tick;
    chk("arm", dsc_rdata, 16'h8000);
    core.tick;
    chk("arm", dsc_rdata, 16'h0);
    core.issue(`PSM_OP_SLEEP);
    chk("mode", mode_r, `PSM_ST_SLEEP);
    wake;
end
endtask
// deep sleep ignores interrupts, only reset leaves it
task t_deep;
begin
    core.arm;
    core.issue(`PSM_OP_SLEEP);
    chk("mode", mode_r, `PSM_ST_DEEP);
    chk("pwr", {mem_power_en, io_freeze, keep_calendar_wdt}, 3'h3);
    wake_deep_probe: begin
        irq_pending = 1'h1;
        cyc(3);
        irq_pending = 1'h0;
    end
    chk("mode", mode_r, `PSM_ST_DEEP);
    rst;
end
endtask
task results;
begin
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
        $display("TB: PASS");
    else
        $display("TB: FAIL");
    $finish;
end
endtask
// main sequence
initial begin
    rst;
    sw(1'h0, 3'h5, 3'h5);
    sw(1'h1, 3'h2, 3'h5);
    t_sleep;
    t_idle;
    t_coinc;
    t_window;
    t_deep;
    results;
end
// watchdog, far beyond the roughly 80 cycles needed
initial begin
    #100000;
    bad_count = bad_count + 1;
    results;
end
endmodule // tb
